// ### inc/iahc_cfg.svh
// Purpose : Constants for the interrupt and halt control block
// Assumes : Included by the design files and by the testbench
// Notes   : Offsets are byte addresses on the 32-bit register bus
`ifndef IAHC_CFG_SVH
`define IAHC_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define IAHC_OFS_REQ      8'h00
`define IAHC_OFS_EN       8'h04
`define IAHC_OFS_STAT     8'h08

// ----------------------------------------------------------------------
// Source bit positions, vectors and reset values
// ----------------------------------------------------------------------
`define IAHC_SRC_NUM      3
`define IAHC_BIT_IVT      0
`define IAHC_BIT_EXT      1
`define IAHC_BIT_TM8      2
`define IAHC_VEC_IVT      16'h0001
`define IAHC_VEC_EXT      16'h0002
`define IAHC_VEC_TM8      16'h0003
`define IAHC_RST_EN       3'h0
`define IAHC_RST_REQ      1'b0

// ----------------------------------------------------------------------
// Standby operands
// ----------------------------------------------------------------------
`define IAHC_OPND_TM8     4'h2
`define IAHC_OPND_ANY     4'h8

`endif

// ### inc/iahc_pkg.sv
// Purpose : Types shared by the interrupt and halt control files
// Assumes : Sequencer signals are on the same clock as the block
// Notes   : State and opcode codes are one-hot
package iahc_pkg;

	// ------------------------------------------------------------------
	// Controller state and decoded instruction class
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_RUN    = 4'h1,
		ST_ACCEPT = 4'h2,
		ST_HALT   = 4'h4,
		ST_STOP   = 4'h8
	} iahc_state_t;

	typedef enum logic [5:0] {
		OP_NONE = 6'h01,
		OP_EI   = 6'h02,
		OP_DI   = 6'h04,
		OP_INTERRUPT_RETURN_INSTR = 6'h08,
		OP_HALT = 6'h10,
		OP_STOP = 6'h20
	} iahc_op_t;

	// ------------------------------------------------------------------
	// Sequencer request and controller answer
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       cycle_end;   // Pulse: an instruction cycle ends
		logic       last_cycle;  // This cycle is the instruction's last
		iahc_op_t   op;          // Class of the instruction ending
		logic [3:0] operand;     // Standby operand
	} iahc_cpu_req_t;

	typedef struct packed {
		logic        accept;     // Acceptance cycle in progress
		logic        push;       // Push return address and flags
		logic [15:0] vector;     // Vector for program counter load
		logic        restore;    // Return: pop address and flags
		logic        halted;     // Instruction execution stopped
		logic        clk_stop;   // System clock to be stopped
		logic        resume;     // Continue with the next instruction
	} iahc_cpu_rsp_t;

endpackage : iahc_pkg

// ### src/iahc_req_flag.sv
// Purpose : One interrupt request flag
// Assumes : All inputs are on clk_i
// Notes   : A hardware set wins over any clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
`include "iahc_cfg.svh"

module iahc_req_flag
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic hw_set_i,
	input  wire logic force_set_i,
	input  wire logic sw_wr_i,
	input  wire logic sw_val_i,
	input  wire logic take_clr_i,
	output var  logic flag_o
);
	logic flag_nxt;

	// Set by the source first, then the acceptance clear, then software
	always_comb
	begin
		flag_nxt = flag_o;
		if (hw_set_i || force_set_i)
			flag_nxt = 1'b1;
		else if (take_clr_i)
			flag_nxt = 1'b0;
		else if (sw_wr_i)
			flag_nxt = sw_val_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			flag_o <= `IAHC_RST_REQ;
		else
			flag_o <= flag_nxt;
	end

endmodule : iahc_req_flag
`default_nettype wire

// ### src/iahc_ctrl.sv
// Purpose : Interrupt request, enable, acceptance and standby control
// Assumes : Sequencer and interrupt sources run on clk_i (10 MHz)
// Notes   : Key port pins arrive asynchronously and are synchronised
//
// How it works
// - Every source has an enable bit; one permits, zero blocks it.
// - A source event sets its request; acceptance clears it.
// - Software writes request bits: one raises a request, zero cancels.
// - Leaving stop mode forces the request flag to one.
// - Enabled requests are taken only at the instruction's end or on halt release.
// - Two-cycle instructions are interrupted only after their second cycle.
// - Disabled requests stay pending and are taken once enabled.
// - The highest-priority enabled request goes first; others wait.
// - Acceptance takes exactly one instruction cycle.
// - The return instruction restores and returns in one cycle.
// - Global enable acts only after the following instruction.
// - Halt stops execution, clock runs, until its release.
// - Stop halts clock and execution until its release.
// - Halt instruction enters halt; stop instruction enters stop.
// - Halt with operand two ends on a timer request.
// - Halt with operand eight ends on any enabled request.
// - Halt with operand eight also ends on a low key pin.
// - A pin release resumes at the next instruction regardless.
// - Requests from disabled sources never end operand-eight halt.
// - Enabled release: resume if globally masked, else take vector.
// - Timer release resumes, vectoring only if both enables set.
// - Priority: timer 0003, pin edge 0002, interval timer 0001.
// - Global enable: set by enable-all, cleared by mask, take, reset.
// - A halt whose conditions fail acts as a no-operation.
`timescale 1ns/1ps
`default_nettype none
`include "iahc_cfg.svh"

module iahc_ctrl
#(
	parameter int PIN_SYNC = 2
)
(
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	// Wishbone slave
	input  wire logic [7:0]             adr_i,
	input  wire logic [31:0]            dat_i,
	input  wire logic [3:0]             sel_i,
	input  wire logic                   we_i,
	input  wire logic                   cyc_i,
	input  wire logic                   stb_i,
	output var  logic [31:0]            dat_o,
	output var  logic                   ack_o,
	// Interrupt sources, one-cycle pulses
	input  wire logic                   timer8_request_i,
	input  wire logic                   ext_pin_request_i,
	input  wire logic                   interval_timer_request_i,
	// Key port pins and port input configuration (1 = input)
	input  wire logic [3:0]             key_port_a_pins_i,
	input  wire logic [3:0]             key_port_b_pins_i,
	input  wire logic [3:0]             key_port_c_pins_i,
	input  wire logic [3:0]             key_port_d_pins_i,
	input  wire logic [11:0]            port_bcd_is_input_i,
	// Instruction sequencer
	input  wire iahc_pkg::iahc_cpu_req_t cpu_req_i,
	output var  iahc_pkg::iahc_cpu_rsp_t cpu_rsp_o
);
	import iahc_pkg::*;

	localparam int N = `IAHC_SRC_NUM;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	iahc_state_t    state_r;
	iahc_state_t    state_nxt;
	iahc_cpu_rsp_t  rsp_nxt;
	logic [3:0]     halt_mode_r;
	logic [3:0]     halt_mode_nxt;
	logic           global_int_enable_r;
	logic           ge_nxt;
	logic           ei_arm_r;
	logic           ei_arm_nxt;
	logic [N-1:0]   source_enable_flag_r;
	logic [N-1:0]   source_request_flag;
	logic [N-1:0]   hw_set;
	logic [N-1:0]   take_clr;
	logic           force_tm8;
	logic [15:0]    pin_s1_r;
	logic [15:0]    pin_s2_r;
	logic           ack_r;
	logic [31:0]    dat_r;
	logic           unused_ok;

	// ------------------------------------------------------------------
	// Pin synchroniser: only the second stage is looked at
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pin_s1_r <= 16'hffff;
			pin_s2_r <= 16'hffff;
		end
		else
		begin
			pin_s1_r <= {key_port_d_pins_i, key_port_c_pins_i,
			             key_port_b_pins_i, key_port_a_pins_i};
			pin_s2_r <= pin_s1_r;
		end
	end

	// Port A always counts; B, C, D only where configured as inputs
	wire [11:0] bcd_low   = port_bcd_is_input_i & ~pin_s2_r[15:4];
	wire        pin_low   = ~&pin_s2_r[3:0] | (|bcd_low);
	wire        pins_high = ~pin_low;

	// ------------------------------------------------------------------
	// Sequencer decode and request selection
	// ------------------------------------------------------------------
	// A two-cycle instruction marks only its second cycle as last, so
	// no interrupt slips in between its two cycles.
	wire boundary = cpu_req_i.cycle_end & cpu_req_i.last_cycle;
	wire is_ei    = boundary & (cpu_req_i.op == OP_EI);
	wire is_di    = boundary & (cpu_req_i.op == OP_DI);
	wire is_interrupt_return_instr  = boundary & (cpu_req_i.op == OP_INTERRUPT_RETURN_INSTR);
	wire is_halt  = boundary & (cpu_req_i.op == OP_HALT);
	wire is_stop  = boundary & (cpu_req_i.op == OP_STOP);
	wire opnd_tm8 = cpu_req_i.operand == `IAHC_OPND_TM8;
	wire opnd_any = cpu_req_i.operand == `IAHC_OPND_ANY;

	// Only individually enabled requests count below, except the raw timer flag in the timer halt checks
	wire [N-1:0] pend = source_request_flag & source_enable_flag_r;
	wire         any_pend = |pend;

	// Fixed priority: 8-bit timer, then pin edge, then interval timer
	wire pick_tm8 = pend[`IAHC_BIT_TM8];
	wire pick_ext = ~pick_tm8 & pend[`IAHC_BIT_EXT];
	wire pick_ivt = ~pick_tm8 & ~pick_ext & pend[`IAHC_BIT_IVT];
	wire [15:0] pick_vec = pick_tm8 ? `IAHC_VEC_TM8 :
	                       pick_ext ? `IAHC_VEC_EXT : `IAHC_VEC_IVT;

	// Standby entry checks; a failed check leaves a no-operation
	wire halt_ok_tm8 = opnd_tm8 & ~source_request_flag[`IAHC_BIT_TM8];
	wire halt_ok_any = opnd_any & ~any_pend & pins_high;
	wire halt_go     = is_halt & (halt_ok_tm8 | halt_ok_any);
	wire stop_go     = is_stop & opnd_any & pins_high
	                   & ~pend[`IAHC_BIT_EXT];
	wire take_now    = boundary & global_int_enable_r & any_pend;

	// Halt release decisions
	wire hrel_tm8  = (halt_mode_r == `IAHC_OPND_TM8)
	                 & source_request_flag[`IAHC_BIT_TM8];
	wire hrel_pin  = (halt_mode_r == `IAHC_OPND_ANY) & pin_low;
	wire hrel_int  = (halt_mode_r == `IAHC_OPND_ANY) & any_pend;
	wire tm8_vec   = global_int_enable_r & pend[`IAHC_BIT_TM8];
	wire int_vec   = global_int_enable_r & any_pend;
	wire stop_rel  = pin_low | pend[`IAHC_BIT_EXT];

	// ------------------------------------------------------------------
	// State machine
	// ------------------------------------------------------------------
	always_comb
	begin
		state_nxt     = state_r;
		halt_mode_nxt = halt_mode_r;
		case (state_r)
			ST_RUN:
			begin
				if (take_now)
					state_nxt = ST_ACCEPT;
				else if (halt_go)
				begin
					state_nxt     = ST_HALT;
					halt_mode_nxt = cpu_req_i.operand;
				end
				else if (stop_go)
					state_nxt = ST_STOP;
			end
			ST_ACCEPT:
			begin
				// The acceptance work spans one instruction cycle
				if (cpu_req_i.cycle_end)
					state_nxt = ST_RUN;
			end
			ST_HALT:
			begin
				// Clock keeps running; only a release leaves this state
				if (hrel_tm8)
					state_nxt = tm8_vec ? ST_ACCEPT : ST_RUN;
				else if (hrel_pin)
					state_nxt = ST_RUN;
				else if (hrel_int)
					state_nxt = int_vec ? ST_ACCEPT : ST_RUN;
			end
			ST_STOP:
			begin
				// Leave through a timer halt, which then sees its flag
				if (stop_rel)
				begin
					state_nxt     = ST_HALT;
					halt_mode_nxt = `IAHC_OPND_TM8;
				end
			end
			default:
			begin
				state_nxt = ST_RUN;
			end
		endcase
	end

	wire entering_take = (state_nxt == ST_ACCEPT) & (state_r != ST_ACCEPT);
	assign force_tm8   = (state_r == ST_STOP) & stop_rel;

	// ------------------------------------------------------------------
	// Global enable: armed by enable-all, live after the next instruction
	// ------------------------------------------------------------------
	always_comb
	begin
		ge_nxt     = global_int_enable_r;
		ei_arm_nxt = ei_arm_r;
		if (boundary)
		begin
			ei_arm_nxt = is_ei;
			if (ei_arm_r)
				ge_nxt = 1'b1;
		end
		if (is_di || entering_take)
		begin
			ge_nxt     = 1'b0;
			ei_arm_nxt = 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Answer to the sequencer
	// ------------------------------------------------------------------
	always_comb
	begin
		rsp_nxt          = '0;
		rsp_nxt.accept   = state_nxt == ST_ACCEPT;
		rsp_nxt.push     = entering_take;
		rsp_nxt.vector   = entering_take ? pick_vec : cpu_rsp_o.vector;
		rsp_nxt.restore  = is_interrupt_return_instr & (state_r == ST_RUN);
		rsp_nxt.halted   = (state_nxt == ST_HALT) | (state_nxt == ST_STOP);
		rsp_nxt.clk_stop = state_nxt == ST_STOP;
		rsp_nxt.resume   = (state_r == ST_HALT) & (state_nxt == ST_RUN);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r             <= ST_RUN;
			halt_mode_r         <= 4'h0;
			global_int_enable_r <= 1'b0;
			ei_arm_r            <= 1'b0;
			cpu_rsp_o           <= '0;
		end
		else
		begin
			state_r             <= state_nxt;
			halt_mode_r         <= halt_mode_nxt;
			global_int_enable_r <= ge_nxt;
			ei_arm_r            <= ei_arm_nxt;
			cpu_rsp_o           <= rsp_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Wishbone slave: ack one cycle after the strobe, drop it after
	// ------------------------------------------------------------------
	// Writes land on the edge at which the master sees ack high
	wire wb_req = cyc_i & stb_i;
	wire wb_wr  = wb_req & ack_r & we_i & sel_i[0];
	wire wr_req = wb_wr & (adr_i == `IAHC_OFS_REQ);
	wire wr_en  = wb_wr & (adr_i == `IAHC_OFS_EN);
	wire [31:0] rd_mux =
		(adr_i == `IAHC_OFS_REQ)  ? {29'h0, source_request_flag} :
		(adr_i == `IAHC_OFS_EN)   ? {29'h0, source_enable_flag_r} :
		(adr_i == `IAHC_OFS_STAT) ? {22'h0, halt_mode_r, state_r,
		                             ei_arm_r, global_int_enable_r} :
		32'h0;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_r                <= 1'b0;
			dat_r                <= 32'h0;
			source_enable_flag_r <= `IAHC_RST_EN;
		end
		else
		begin
			ack_r <= wb_req & ~ack_r;
			dat_r <= rd_mux;
			if (wr_en)
				source_enable_flag_r <= dat_i[N-1:0];
		end
	end

	assign ack_o = ack_r;
	assign dat_o = dat_r;
	assign unused_ok = ^{dat_i[31:N], sel_i[3:1]};

	// ------------------------------------------------------------------
	// Request flags, one cell per source
	// ------------------------------------------------------------------
	assign hw_set   = {timer8_request_i, ext_pin_request_i,
	                   interval_timer_request_i};
	assign take_clr = entering_take ? {pick_tm8, pick_ext, pick_ivt}
	                                : 3'h0;

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_flag
			iahc_req_flag u_flag
			(
				.clk_i       (clk_i),
				.rst_i       (rst_i),
				.hw_set_i    (hw_set[g]),
				.force_set_i (force_tm8 && (g == `IAHC_BIT_TM8)),
				.sw_wr_i     (wr_req),
				.sw_val_i    (dat_i[g]),
				.take_clr_i  (take_clr[g]),
				.flag_o      (source_request_flag[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_take_clears_ge;
		rsp_nxt.push |=> !global_int_enable_r && cpu_rsp_o.push;
	endproperty
	a_take_clears_ge: assert property (p_take_clears_ge)
		else $error("global enable still set after acceptance");

	property p_accept_one;
		state_r == ST_ACCEPT && cpu_req_i.cycle_end |=> state_r == ST_RUN;
	endproperty
	a_accept_one: assert property (p_accept_one)
		else $error("acceptance lasted more than one cycle");

	property p_masked_no_take;
		state_r == ST_RUN && boundary && !global_int_enable_r
		|=> !cpu_rsp_o.push;
	endproperty
	a_masked_no_take: assert property (p_masked_no_take)
		else $error("request taken while globally masked");

	property p_timer_first;
		state_r == ST_RUN && take_now && pend[`IAHC_BIT_TM8]
		|=> cpu_rsp_o.vector == `IAHC_VEC_TM8;
	endproperty
	a_timer_first: assert property (p_timer_first)
		else $error("timer request did not win priority");

	property p_ei_delay;
		state_r == ST_RUN && is_ei && !ei_arm_r && !global_int_enable_r
		|=> !global_int_enable_r;
	endproperty
	a_ei_delay: assert property (p_ei_delay)
		else $error("global enable acted too early");

	property p_halt_nop;
		state_r == ST_RUN && is_halt && !take_now && !opnd_tm8 && !opnd_any
		|=> state_r == ST_RUN;
	endproperty
	a_halt_nop: assert property (p_halt_nop)
		else $error("halt with bad operand entered standby");

	property p_pin_resume;
		state_r == ST_HALT && hrel_pin && !hrel_tm8
		|=> state_r == ST_RUN && cpu_rsp_o.resume ##1 !cpu_rsp_o.resume;
	endproperty
	a_pin_resume: assert property (p_pin_resume)
		else $error("pin release did not resume");

	property p_interrupt_return_instr_one;
		state_r == ST_RUN && is_interrupt_return_instr
		|=> cpu_rsp_o.restore ##1 !cpu_rsp_o.restore;
	endproperty
	a_interrupt_return_instr_one: assert property (p_interrupt_return_instr_one)
		else $error("return restore not a single pulse");

	property p_stop_clock;
		state_r == ST_STOP |-> cpu_rsp_o.clk_stop && cpu_rsp_o.halted;
	endproperty
	a_stop_clock: assert property (p_stop_clock)
		else $error("stop state without clock stop");

endmodule : iahc_ctrl
`default_nettype wire

// ### bench/iahc_seq_model.sv
// Purpose : Behavioural instruction sequencer facing the controller
// Assumes : The testbench calls instr right after a rising edge
// Notes   : Strobes change only by non-blocking assignment after an edge
`timescale 1ns/1ps
`default_nettype none

module iahc_seq_model
(
	input  wire logic                    clk_i,
	input  wire logic                    halted_i,
	output var  iahc_pkg::iahc_cpu_req_t cpu_req_o
);
	import iahc_pkg::*;

	// ------------------------------------------------------------------
	// Instruction cycle ends
	// ------------------------------------------------------------------
	// Idle sequencer: no cycle end, plain one-cycle instruction
	initial cpu_req_o = '{1'b0, 1'b1, OP_NONE, 4'h0};

	// One instruction end after gap idle cycles; gap of at least one
	// keeps two ends from landing in one time step
	task automatic instr(input iahc_op_t op, input logic [3:0] opnd,
		input logic last, input int gap);
		repeat (gap) @(posedge clk_i);
		// Nothing executes in standby, so no cycle end then
		if (halted_i !== 1'b1)
		begin
			cpu_req_o <= '{1'b1, last, op, opnd};
			@(posedge clk_i);
			cpu_req_o.cycle_end <= 1'b0;
		end
	endtask : instr

endmodule : iahc_seq_model
`default_nettype wire

// ### bench/testbench.sv
// Purpose : Self-checking bench for the interrupt and halt controller
// Assumes : Sequencer model answers every instruction call
// Notes   : Event pulses are counted on the falling edge, when settled
`timescale 1ns/1ps
`default_nettype none
`include "iahc_cfg.svh"

module testbench;
	import iahc_pkg::*;

	// ------------------------------------------------------------------
	// Stimulus, design and counters
	// ------------------------------------------------------------------
	localparam logic [7:0] A_REQ = `IAHC_OFS_REQ;
	localparam logic [7:0] A_EN  = `IAHC_OFS_EN;
	localparam logic [7:0] A_ST  = `IAHC_OFS_STAT;
	logic          clk_i = 1'b0;
	logic          rst_i = 1'b1;
	logic [7:0]    adr = 8'h00;
	logic [31:0]   wdat = 32'h0;
	logic          we = 1'b0;
	logic          cyc = 1'b0;
	logic          stb = 1'b0;
	logic [31:0]   dat_o;
	logic          ack_o;
	logic [2:0]    src = 3'h0; // {tm8, ext, ivt}
	logic [3:0]    pa = 4'hf;
	logic [3:0]    pb = 4'hf;
	logic [11:0]   pin_in = 12'h000;
	iahc_cpu_req_t req;
	iahc_cpu_rsp_t rsp;
	int            miscompares = 0;
	int            checks = 0;
	int            ev_cnt[3] = '{0, 0, 0}; // push, resume, restore
	int            ev_exp[3] = '{0, 0, 0};
	logic [15:0]   last_vec = 16'h0;

	always #50 clk_i = ~clk_i;

	iahc_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
		.dat_i(wdat), .sel_i(4'hf), .we_i(we), .cyc_i(cyc), .stb_i(stb),
		.dat_o(dat_o), .ack_o(ack_o), .timer8_request_i(src[2]),
		.ext_pin_request_i(src[1]), .interval_timer_request_i(src[0]),
		.key_port_a_pins_i(pa), .key_port_b_pins_i(pb),
		.key_port_c_pins_i(4'hf), .key_port_d_pins_i(4'hf),
		.port_bcd_is_input_i(pin_in), .cpu_req_i(req), .cpu_rsp_o(rsp));

	iahc_seq_model u_seq (.clk_i(clk_i), .halted_i(rsp.halted),
		.cpu_req_o(req));

	// Falling edge avoids racing the bench process at the rising edge
	always @(negedge clk_i)
	begin
		if (rsp.push === 1'b1)
		begin
			ev_cnt[0]++;
			last_vec = rsp.vector;
		end
		if (rsp.resume === 1'b1)
			ev_cnt[1]++;
		if (rsp.restore === 1'b1)
			ev_cnt[2]++;
	end

	// ------------------------------------------------------------------
	// Bus, check and helper tasks
	// ------------------------------------------------------------------
	task results;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// Classic single cycle; the bound catches a slave that never answers
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk_i);
		while (ack_o !== 1'b1 && n < 20)
		begin
			@(posedge clk_i);
			n++;
		end
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
		if (n >= 20)
		begin
			miscompares++;
			results();
		end
	endtask : wb

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask : wr

	task rd(input string nm, input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(nm, {24'h0, q[7:0] & m}, {24'h0, e});
	endtask : rd

	// Quiet window first, then a bounded wait for the expected count
	task ev(input int i, input int add, input string nm);
		int n;
		ev_exp[i] += add;
		repeat (4) @(posedge clk_i);
		for (n = 0; n < 20 && ev_cnt[i] != ev_exp[i]; n++)
			@(posedge clk_i);
		chk(nm, ev_cnt[i], ev_exp[i]);
		if (ev_cnt[i] != ev_exp[i])
			results();
	endtask : ev

	task ins(input iahc_op_t op, input logic [3:0] o);
		u_seq.instr(op, o, 1'b1, 1);
	endtask : ins

	task arm;
		ins(OP_EI, 4'h0);
		ins(OP_NONE, 4'h0);
	endtask : arm

	task pul(input int b);
		@(posedge clk_i);
		src[b] <= 1'b1;
		@(posedge clk_i);
		src[b] <= 1'b0;
	endtask : pul

	task stl;
		repeat (3) @(posedge clk_i);
	endtask : stl

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task t_reset;
		rd("req", A_REQ, 8'h07, 8'h00);
		rd("en", A_EN, 8'h07, 8'h00);
		rd("stat", A_ST, 8'h3f, 8'h04);
		rd("unmapped", 8'h10, 8'hff, 8'h00);
		wr(A_REQ, 32'h5);
		rd("req", A_REQ, 8'h07, 8'h05);
		wr(A_REQ, 32'h0);
		rd("req", A_REQ, 8'h07, 8'h00);
		$display("test reset done");
	endtask : t_reset

	task t_take;
		pul(2);
		rd("req", A_REQ, 8'h07, 8'h04);
		ins(OP_EI, 4'h0);
		rd("ge", A_ST, 8'h01, 8'h00);
		ins(OP_NONE, 4'h0);
		rd("ge", A_ST, 8'h01, 8'h01);
		ins(OP_NONE, 4'h0);
		ev(0, 0, "push");
		wr(A_EN, 32'h4);
		ins(OP_NONE, 4'h0);
		ev(0, 1, "push");
		chk("vec", last_vec, 16'h3);
		rd("req", A_REQ, 8'h07, 8'h00);
		rd("stat", A_ST, 8'h3d, 8'h08);
		ins(OP_NONE, 4'h0);
		stl();
		chk("accept", rsp.accept, 1'b0);
		rd("stat", A_ST, 8'h3d, 8'h04);
		// Mask-all must drop the live enable; no arm is pending at this point
		arm();
		rd("ge", A_ST, 8'h03, 8'h01);
		ins(OP_DI, 4'h0);
		rd("ge", A_ST, 8'h03, 8'h00);
		$display("test take done");
	endtask : t_take

	task t_prio;
		wr(A_EN, 32'h7);
		wr(A_REQ, 32'h7);
		arm();
		ins(OP_NONE, 4'h0);
		ev(0, 1, "push");
		chk("vec", last_vec, 16'h3);
		rd("req", A_REQ, 8'h07, 8'h03);
		ins(OP_NONE, 4'h0);
		ins(OP_EI, 4'h0);
		ins(OP_INTERRUPT_RETURN_INSTR, 4'h0);
		ev(2, 1, "restore");
		ev(0, 0, "push");
		u_seq.instr(OP_NONE, 4'h0, 1'b0, 1);
		ev(0, 0, "push");
		ins(OP_NONE, 4'h0);
		ev(0, 1, "push");
		chk("vec", last_vec, 16'h2);
		ins(OP_NONE, 4'h0);
		arm();
		ins(OP_NONE, 4'h0);
		ev(0, 1, "push");
		chk("vec", last_vec, 16'h1);
		ins(OP_NONE, 4'h0);
		rd("req", A_REQ, 8'h07, 8'h00);
		$display("test priority done");
	endtask : t_prio

	task t_halt8;
		wr(A_EN, 32'h0);
		ins(OP_HALT, 4'h8);
		stl();
		chk("halted", rsp.halted, 1'b1);
		rd("stat", A_ST, 8'h3c, 8'h10);
		pb <= 4'h0;
		ev(1, 0, "resume");
		pin_in <= 12'h00f;
		ev(1, 1, "resume");
		pb <= 4'hf;
		pin_in <= 12'h000;
		stl();
		ins(OP_HALT, 4'h8);
		stl();
		pa <= 4'hb;
		ev(1, 1, "resume");
		pa <= 4'hf;
		stl();
		wr(A_EN, 32'h2);
		ins(OP_HALT, 4'h8);
		pul(0);
		ev(1, 0, "resume");
		pul(1);
		ev(1, 1, "resume");
		ins(OP_HALT, 4'h8);
		stl();
		chk("halted", rsp.halted, 1'b0);
		// Cleared well ahead of the next halt, never just before it
		wr(A_REQ, 32'h0);
		arm();
		ins(OP_HALT, 4'h8);
		pul(1);
		ev(0, 1, "push");
		chk("vec", last_vec, 16'h2);
		ins(OP_NONE, 4'h0);
		$display("test halt8 done");
	endtask : t_halt8

	task t_halt2;
		wr(A_EN, 32'h0);
		ins(OP_HALT, 4'h3);
		stl();
		chk("halted", rsp.halted, 1'b0);
		ins(OP_HALT, 4'h2);
		pul(0);
		ev(1, 0, "resume");
		pul(2);
		ev(1, 1, "resume");
		rd("req", A_REQ, 8'h07, 8'h05);
		ins(OP_HALT, 4'h2);
		stl();
		chk("halted", rsp.halted, 1'b0);
		wr(A_REQ, 32'h0);
		wr(A_EN, 32'h4);
		arm();
		ins(OP_HALT, 4'h2);
		pul(2);
		ev(0, 1, "push");
		chk("vec", last_vec, 16'h3);
		ins(OP_NONE, 4'h0);
		wr(A_EN, 32'h0);
		$display("test halt2 done");
	endtask : t_halt2

	task t_stop;
		ins(OP_STOP, 4'h8);
		stl();
		chk("clk_stop", rsp.clk_stop, 1'b1);
		chk("halted", rsp.halted, 1'b1);
		pa <= 4'he;
		ev(1, 1, "resume");
		pa <= 4'hf;
		chk("clk_stop", rsp.clk_stop, 1'b0);
		rd("req", A_REQ, 8'h07, 8'h04);
		$display("test stop done");
	endtask : t_stop

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_take();
		t_prio();
		t_halt8();
		t_halt2();
		t_stop();
		results();
	end

endmodule : testbench
`default_nettype wire
